// ===== hw/bbs_exec.sv
/*
  Execution core for the zero-clear branch, overflow-clear branch,
  relative jump and file bit set, with a Wishbone classic register slave.
  Assumes the data memory answers a read strobe with data by the next
  phase tick and holds it; ALU flags arrive on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module bbs_exec #(
  parameter int unsigned STEP_CYC = bbs_pkg::QPHASE_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [bbs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic aluZero,
  input wire logic aluOverflow,
  input wire logic [7:0] memRdata,
  output bbs_pkg::bbs_mem_req_s memReq,
  output logic [bbs_pkg::PC_W-1:0] pcOut,
  output logic flushStb
);

  // Byte-lane merge for partial writes
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] sel
  );
    int i;
    mergeBytes = oldVal;
    for (i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        mergeBytes[8*i +: 8] = newVal[8*i +: 8];
      end
    end
  endfunction

  // ==========================================================
  // State
  logic ackQ;
  logic [31:0] datQ;
  logic extQ;
  logic [15:0] instrQ;
  logic [15:0] irQ;
  logic pendQ;
  logic [bbs_pkg::PC_W-1:0] pcQ;
  logic [3:0] bankQ;
  logic [bbs_pkg::DA_W-1:0] idxQ;
  logic illQ;
  logic takenQ;
  logic [bbs_pkg::PC_W-1:0] dispQ;
  logic [bbs_pkg::PC_W-1:0] targetQ;
  logic flushQ;
  bbs_pkg::bbs_mem_req_s memQ;
  bbs_pkg::bbs_state_e stateQ;
  bbs_pkg::bbs_state_e stateD;

  // ==========================================================
  // Phase sequencer and decoder
  logic tick;
  bbs_pkg::bbs_phase_e phase;
  logic isZclr;
  logic isOvclr;
  logic isJump;
  logic isBset;
  logic [bbs_pkg::PC_W-1:0] disp;
  logic [7:0] bitMask;
  logic [bbs_pkg::DA_W-1:0] dataAddr;

  bbs_qphase #(
    .STEP_CYC(STEP_CYC)
  ) u_qphase (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(tick),
    .phase(phase)
  );

  bbs_decode u_decode (
    .instr(irQ),
    .bankSel(bankQ),
    .idxBase(idxQ),
    .extEn(extQ),
    .isZclr(isZclr),
    .isOvclr(isOvclr),
    .isJump(isJump),
    .isBset(isBset),
    .disp(disp),
    .bitMask(bitMask),
    .dataAddr(dataAddr)
  );

  // ==========================================================
  // Bus decode
  wire wbReq = wb_cyc_i && wb_stb_i && !ackQ;
  wire wbWr = wbReq && wb_we_i;
  wire hitCtrl = (wb_adr_i == bbs_pkg::REG_CTRL);
  wire hitInstr = (wb_adr_i == bbs_pkg::REG_INSTR);
  wire hitPc = (wb_adr_i == bbs_pkg::REG_PC);
  wire hitBank = (wb_adr_i == bbs_pkg::REG_BANK);
  wire hitIdx = (wb_adr_i == bbs_pkg::REG_IDX);
  wire hitStat = (wb_adr_i == bbs_pkg::REG_STAT);
  wire busy = (stateQ != bbs_pkg::S_IDLE);
  // PC and instruction only accepted while nothing is queued or running
  wire quiet = !busy && !pendQ;

  wire [31:0] mCtrl = mergeBytes({31'h0, extQ}, wb_dat_i, wb_sel_i);
  wire [31:0] mInstr = mergeBytes({16'h0, instrQ}, wb_dat_i, wb_sel_i);
  wire [31:0] mPc = mergeBytes({11'h0, pcQ}, wb_dat_i, wb_sel_i);
  wire [31:0] mBank = mergeBytes({28'h0, bankQ}, wb_dat_i, wb_sel_i);
  wire [31:0] mIdx = mergeBytes({20'h0, idxQ}, wb_dat_i, wb_sel_i);
  wire illClr = wbWr && hitStat && wb_sel_i[0] && wb_dat_i[bbs_pkg::STAT_ILL_BIT];

  wire [31:0] statWord = {26'h0, phase, illQ, takenQ, pendQ, busy};
  wire [31:0] rdMux =
    hitCtrl ? {31'h0, extQ} :
    hitInstr ? {16'h0, instrQ} :
    hitPc ? {11'h0, pcQ} :
    hitBank ? {28'h0, bankQ} :
    hitIdx ? {20'h0, idxQ} :
    hitStat ? statWord :
    32'h0000_0000;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ackQ <= 1'b0;
      datQ <= 32'h0000_0000;
    end
    else
    begin
      ackQ <= wbReq;
      datQ <= wbReq ? rdMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      extQ <= bbs_pkg::RST_EXT;
      bankQ <= bbs_pkg::RST_BANK;
      idxQ <= bbs_pkg::RST_IDX;
    end
    else if (wbWr)
    begin
      if (hitCtrl)
        extQ <= mCtrl[bbs_pkg::CTRL_EXT_BIT];
      if (hitBank)
        bankQ <= mBank[3:0];
      if (hitIdx)
        idxQ <= mIdx[bbs_pkg::DA_W-1:0];
    end
  end

  // ==========================================================
  // Sequencing
  wire atQ1 = tick && (phase == bbs_pkg::PH_Q1);
  wire inExec = tick && (stateQ == bbs_pkg::S_EXEC);
  wire exQ2 = inExec && (phase == bbs_pkg::PH_Q2);
  wire exQ3 = inExec && (phase == bbs_pkg::PH_Q3);
  wire exQ4 = inExec && (phase == bbs_pkg::PH_Q4);
  wire start = atQ1 && pendQ && (stateQ == bbs_pkg::S_IDLE);
  wire isBranch = isZclr || isOvclr || isJump;
  wire known = isBranch || isBset;
  wire condOk = isJump || (isZclr && !aluZero) || (isOvclr && !aluOverflow);
  wire [bbs_pkg::PC_W-1:0] pcInc = pcQ + bbs_pkg::PC_W'(2);
  wire jumpNow = exQ4 && isBranch && takenQ;

  always_comb
  begin
    stateD = stateQ;
    case (stateQ)
      bbs_pkg::S_IDLE:
        if (start)
          stateD = bbs_pkg::S_EXEC;
      bbs_pkg::S_EXEC:
        if (exQ4)
          stateD = jumpNow ? bbs_pkg::S_FLUSH : bbs_pkg::S_IDLE;
      bbs_pkg::S_FLUSH:
        // Full dead cycle, Q1 through Q4, nothing written
        if (tick && (phase == bbs_pkg::PH_Q4))
          stateD = bbs_pkg::S_IDLE;
      default:
        stateD = bbs_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateQ <= bbs_pkg::S_IDLE;
      instrQ <= bbs_pkg::RST_INSTR;
      irQ <= bbs_pkg::RST_INSTR;
      pendQ <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
      if (wbWr && hitInstr && quiet)
      begin
        instrQ <= mInstr[15:0];
        pendQ <= 1'b1;
      end
      else if (start)
      begin
        irQ <= instrQ; // Q1 decode
        pendQ <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Branch datapath
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dispQ <= '0;
      targetQ <= bbs_pkg::RST_PC;
      takenQ <= 1'b0;
    end
    else
    begin
      if (exQ2)
        dispQ <= disp; // Literal read
      if (exQ3)
      begin
        takenQ <= isBranch && condOk;
        targetQ <= pcInc + dispQ;
      end
    end
  end

  // Flags are only read here; nothing in this block drives them
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pcQ <= bbs_pkg::RST_PC;
      flushQ <= 1'b0;
    end
    else
    begin
      flushQ <= jumpNow;
      if (exQ4)
        pcQ <= jumpNow ? targetQ : pcInc;
      else if (wbWr && hitPc && quiet)
        pcQ <= {mPc[bbs_pkg::PC_W-1:1], 1'b0};
    end
  end

  // ==========================================================
  // Bit set datapath
  // Read-modify-write of one byte; the flags are never touched
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memQ <= '0;
    end
    else
    begin
      memQ.rd <= exQ2 && isBset;
      memQ.wr <= exQ4 && isBset;
      if (exQ2)
        memQ.addr <= dataAddr;
      if (exQ3)
        memQ.wdata <= memRdata | bitMask;
    end
  end

  // Unknown opcodes retire as a plain step; sticky, set beats clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      illQ <= 1'b0;
    else if (exQ2 && !known)
      illQ <= 1'b1;
    else if (illClr)
      illQ <= 1'b0;
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = ackQ;
  assign wb_dat_o = datQ;
  assign memReq = memQ;
  assign pcOut = pcQ;
  assign flushStb = flushQ;

endmodule

`default_nettype wire

// ===== pkg/bbs_pkg.sv
/*
  Shared constants, types and register map for the branch and bit-set
  execution block. Assumes a single 200 MHz core clock.
*/
`default_nettype none

package bbs_pkg;

  // ==========================================================
  // Widths and timing
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam int ADR_W = 8;
  localparam int CLK_MHZ = 200;
  localparam int QPHASE_NS = 5;
  // Least time, rounded up, never below one cycle
  localparam int QPHASE_RAW = (QPHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int QPHASE_CYC = (QPHASE_RAW < 1) ? 1 : QPHASE_RAW;

  // ==========================================================
  // Opcodes and addressing
  localparam logic [7:0] OP_ZCLR = 8'hE1;
  localparam logic [7:0] OP_OVCLR = 8'hE5;
  localparam logic [4:0] OP_JUMP = 5'h1A;
  localparam logic [3:0] OP_BSET = 4'h8;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;

  // ==========================================================
  // Register map and reset values
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_INSTR = 8'h04;
  localparam logic [ADR_W-1:0] REG_PC = 8'h08;
  localparam logic [ADR_W-1:0] REG_BANK = 8'h0C;
  localparam logic [ADR_W-1:0] REG_IDX = 8'h10;
  localparam logic [ADR_W-1:0] REG_STAT = 8'h14;
  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_TAKEN_BIT = 2;
  localparam int STAT_ILL_BIT = 3;
  localparam int STAT_PH_LSB = 4;
  localparam logic [PC_W-1:0] RST_PC = 21'h000000;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [DA_W-1:0] RST_IDX = 12'h000;
  localparam logic RST_EXT = 1'b0;
  localparam logic [15:0] RST_INSTR = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbs_phase_e;
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_FLUSH} bbs_state_e;

  typedef struct packed {
    logic [DA_W-1:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } bbs_mem_req_s;

endpackage

`default_nettype wire

// ===== hw/bbs_qphase.sv
/*
  Four-phase sequencer: divides the core clock into Q1..Q4 steps.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module bbs_qphase #(
  parameter int unsigned STEP_CYC = bbs_pkg::QPHASE_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  output logic tick,
  output bbs_pkg::bbs_phase_e phase
);

  localparam int CW = $clog2(STEP_CYC + 1);

  // ==========================================================
  // Divider
  logic [CW-1:0] cntQ;
  bbs_pkg::bbs_phase_e phaseQ;
  bbs_pkg::bbs_phase_e phaseD;

  assign tick = (cntQ == CW'(STEP_CYC - 1));
  assign phase = phaseQ;

  always_comb
  begin
    case (phaseQ)
      bbs_pkg::PH_Q1: phaseD = bbs_pkg::PH_Q2;
      bbs_pkg::PH_Q2: phaseD = bbs_pkg::PH_Q3;
      bbs_pkg::PH_Q3: phaseD = bbs_pkg::PH_Q4;
      default: phaseD = bbs_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cntQ <= '0;
      phaseQ <= bbs_pkg::PH_Q1;
    end
    else if (tick)
    begin
      cntQ <= '0;
      phaseQ <= phaseD;
    end
    else
    begin
      cntQ <= cntQ + CW'(1);
    end
  end

endmodule

`default_nettype wire

// ===== hw/bbs_decode.sv
/*
  Opcode decode, displacement and data address forming.
  Purely combinational; the instruction word is held stable by the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module bbs_decode (
  input wire logic [15:0] instr,
  input wire logic [3:0] bankSel,
  input wire logic [bbs_pkg::DA_W-1:0] idxBase,
  input wire logic extEn,
  output logic isZclr,
  output logic isOvclr,
  output logic isJump,
  output logic isBset,
  output logic [bbs_pkg::PC_W-1:0] disp,
  output logic [7:0] bitMask,
  output logic [bbs_pkg::DA_W-1:0] dataAddr
);

  // Doubled, sign-extended offset
  function automatic logic [bbs_pkg::PC_W-1:0] twiceSext(input logic [10:0] v);
    twiceSext = {{(bbs_pkg::PC_W - 12){v[10]}}, v, 1'b0};
  endfunction

  // ==========================================================
  // Opcode classes
  wire [7:0] fileAddr = instr[7:0];
  wire accessBit = instr[8];
  wire [bbs_pkg::PC_W-1:0] shortDisp = twiceSext({{3{instr[7]}}, instr[7:0]});
  wire [bbs_pkg::PC_W-1:0] longDisp = twiceSext(instr[10:0]);

  assign isZclr = (instr[15:8] == bbs_pkg::OP_ZCLR);
  assign isOvclr = (instr[15:8] == bbs_pkg::OP_OVCLR);
  assign isJump = (instr[15:11] == bbs_pkg::OP_JUMP);
  assign isBset = (instr[15:12] == bbs_pkg::OP_BSET);
  assign disp = isJump ? longDisp : shortDisp;
  assign bitMask = 8'h01 << instr[11:9];

  // ==========================================================
  // Bank selection
  wire useIdx = !accessBit && extEn && (fileAddr <= bbs_pkg::IDX_LIMIT);
  wire [bbs_pkg::DA_W-1:0] idxAddr = idxBase + {4'h0, fileAddr};
  wire [bbs_pkg::DA_W-1:0] accAddr = (fileAddr < bbs_pkg::ACC_SPLIT) ?
    {4'h0, fileAddr} : {bbs_pkg::ACC_HI_BANK, fileAddr};
  wire [bbs_pkg::DA_W-1:0] bankAddr = {bankSel, fileAddr};

  assign dataAddr = useIdx ? idxAddr :
    (accessBit ? bankAddr : accAddr);

endmodule

`default_nettype wire

// ===== bench/bbs_exec_assertions.sv
/*
  Port checker for bbs_exec, bound into every instance.
  Assumes STEP_CYC of one and memRdata held through each bit set.
*/
`timescale 1ns/1ps
`default_nettype none

module bbs_exec_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] memRdata,
  input wire bbs_pkg::bbs_mem_req_s memReq,
  input wire logic [bbs_pkg::PC_W-1:0] pcOut,
  input wire logic flushStb
);
  // ==========================================================
  // Bus handshake
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_ackNext;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack late");
  property p_ackPulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
  property p_datIdle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_datIdle: assert property (p_datIdle) else $error("read data not idle");
  // ==========================================================
  // Execution
  property p_rdThenWr;
    memReq.rd |=> !memReq.rd && !memReq.wr ##1 memReq.wr;
  endproperty
  a_rdThenWr: assert property (p_rdThenWr) else $error("write not two after read");
  property p_sameAddr;
    memReq.wr |-> memReq.addr == $past(memReq.addr, 2);
  endproperty
  a_sameAddr: assert property (p_sameAddr) else $error("write address moved");
  property p_setKeeps;
    memReq.wr |-> (memReq.wdata & memRdata) == memRdata
      && $countones(memReq.wdata ^ memRdata) <= 1;
  endproperty
  a_setKeeps: assert property (p_setKeeps) else $error("bit set bad data");
  // Two cycles of slack: pcOut may land with the strobe
  property p_flushDead;
    flushStb |-> ##2 ($stable(pcOut) && !memReq.rd && !memReq.wr)[*3];
  endproperty
  a_flushDead: assert property (p_flushDead) else $error("dead cycle not idle");
  property p_pcEven;
    pcOut[0] == 1'b0;
  endproperty
  a_pcEven: assert property (p_pcEven) else $error("odd program counter");
endmodule

bind bbs_exec bbs_exec_checker i_bbs_exec_checker (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .memRdata(memRdata),
  .memReq(memReq),
  .pcOut(pcOut),
  .flushStb(flushStb)
);

`default_nettype wire

// ===== bench/branch_and_bit_set_exec_bench.sv
/*
  Self-checking bench for bbs_exec: register tasks, branch and bit-set cases.
  Assumes a one-cycle bus answer and STEP_CYC of one.
*/
`timescale 1ns/1ps
`default_nettype none

module branch_and_bit_set_exec_bench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic wbAck;
  logic aluZero = 1'b0;
  logic aluOverflow = 1'b0;
  logic [7:0] memRdata = 8'h00;
  bbs_pkg::bbs_mem_req_s memReq;
  logic [20:0] pcOut;
  logic flushStb;
  logic [11:0] lastAddr;
  logic [7:0] lastData;
  int err_count = 0;
  int tests_run = 0;
  int flushCnt = 0;
  int wrCnt = 0;
  // Free-running phase, restarted by reset
  logic [1:0] phaseRef = 2'h0;

  bbs_exec #(.STEP_CYC(1)) i_bbs_exec (
    .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .aluZero(aluZero), .aluOverflow(aluOverflow),
    .memRdata(memRdata), .memReq(memReq), .pcOut(pcOut), .flushStb(flushStb)
  );

  always #2.5 core_clk = ~core_clk;

  // ==========================================================
  // Observers
  always @(posedge core_clk)
  begin
    phaseRef <= reset_n ? phaseRef + 2'h1 : 2'h0;
    if (flushStb === 1'b1)
      flushCnt++;
    if (memReq.wr === 1'b1)
    begin
      wrCnt++;
      lastAddr <= memReq.addr;
      lastData <= memReq.wdata;
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is seen at an edge
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} <= {2'b11, we, adr, dat, 4'hF};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR;
    if (n >= 50)
      check(32'h0, 32'h1);
    {wbCyc, wbStb, wbWe} <= 3'b000;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wbXfer(1'b1, adr, dat, d);
  endtask

  // Status shows the phase of the edge before the ack edge
  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wbXfer(1'b0, adr, 32'h0, d);
    if (adr == bbs_pkg::REG_STAT)
      exp[5:4] = phaseRef - 2'h1;
    check(d, exp);
  endtask

  // Polls busy and pend; bounded so a hang shows as a mismatch
  task automatic runInstr(input logic [15:0] ins);
    logic [31:0] d;
    int n;
    wr(bbs_pkg::REG_INSTR, {16'h0, ins});
    for (n = 0; n < 40; n++)
    begin
      wbXfer(1'b0, bbs_pkg::REG_STAT, 32'h0, d);
      if (d[1:0] === 2'b00)
        break;
    end
    check(32'(n < 40), 32'h1);
  endtask

  task automatic brTest(input logic [15:0] ins, input logic z, input logic v,
                        input logic [20:0] pc0);
    logic [20:0] exp;
    logic jmp;
    logic tk;
    int f0;
    int w0;
    jmp = ins[15:11] == bbs_pkg::OP_JUMP;
    tk = jmp || (ins[15:8] == bbs_pkg::OP_ZCLR && !z) || (ins[15:8] == bbs_pkg::OP_OVCLR && !v);
    exp = pc0 + 21'h2;
    if (tk)
      exp += jmp ? {{9{ins[10]}}, ins[10:0], 1'b0} : {{12{ins[7]}}, ins[7:0], 1'b0};
    aluZero <= z;
    aluOverflow <= v;
    wr(bbs_pkg::REG_PC, {11'h0, pc0});
    f0 = flushCnt;
    w0 = wrCnt;
    runInstr(ins);
    check({11'h0, pcOut}, {11'h0, exp});
    check(flushCnt - f0, {31'h0, tk});
    check(wrCnt - w0, 32'h0);
  endtask

  task automatic bsTest(input logic [2:0] b, input logic a, input logic [7:0] f,
                        input logic ext, input logic [11:0] idx, input logic [7:0] rdat,
                        input logic [11:0] expAddr);
    int f0;
    int w0;
    wr(bbs_pkg::REG_CTRL, {31'h0, ext});
    wr(bbs_pkg::REG_BANK, 32'h3);
    wr(bbs_pkg::REG_IDX, {20'h0, idx});
    wr(bbs_pkg::REG_PC, 32'h40);
    memRdata <= rdat;
    f0 = flushCnt;
    w0 = wrCnt;
    runInstr({bbs_pkg::OP_BSET, b, a, f});
    check({20'h0, lastAddr}, {20'h0, expAddr});
    check({24'h0, lastData}, {24'h0, rdat | (8'h01 << b)});
    check({11'h0, pcOut}, 32'h42);
    check(wrCnt - w0 + 2 * (flushCnt - f0), 32'h1);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 8'h18; a += 4)
      rdChk(8'(a), 32'h0);
    wr(bbs_pkg::REG_PC, 32'h1235);
    rdChk(bbs_pkg::REG_PC, 32'h1234);
    brTest(16'hE17F, 1'b0, 1'b1, 21'h001000);
    brTest(16'hE180, 1'b0, 1'b0, 21'h001000);
    brTest(16'hE17F, 1'b1, 1'b0, 21'h001000);
    brTest(16'hE505, 1'b1, 1'b0, 21'h000200);
    brTest(16'hE505, 1'b0, 1'b1, 21'h000200);
    brTest(16'hD3FF, 1'b1, 1'b1, 21'h000800);
    brTest(16'hD400, 1'b0, 1'b1, 21'h001000);
    for (int b = 0; b < 8; b++)
      bsTest(3'(b), 1'b1, 8'h80, 1'b0, 12'h000, 8'h00, 12'h380);
    bsTest(3'd7, 1'b1, 8'h25, 1'b1, 12'h100, 8'h0A, 12'h325);
    bsTest(3'd0, 1'b0, 8'h5F, 1'b0, 12'h100, 8'hC6, 12'h05F);
    bsTest(3'd2, 1'b0, 8'h60, 1'b1, 12'h100, 8'h00, 12'hF60);
    bsTest(3'd5, 1'b0, 8'h5F, 1'b1, 12'h100, 8'hFF, 12'h15F);
    // Undefined opcode only steps on and flags it
    wr(bbs_pkg::REG_PC, 32'h100);
    runInstr(16'hFFFF);
    check({11'h0, pcOut}, 32'h102);
    rdChk(bbs_pkg::REG_STAT, 32'h8);
    wr(bbs_pkg::REG_STAT, 32'h8);
    rdChk(bbs_pkg::REG_STAT, 32'h0);
    print_verdict();
  end

  initial
  begin
    #100us;
    err_count++;
    print_verdict();
  end
endmodule

`default_nettype wire
